//--- common/pds_pkg.sv
// package: register map and field layout for the port drive-strength registers
package pds_pkg;

    // ========================================
    // register map
    localparam logic [11:0] ADDR_SEL0     = 12'h000;
    localparam logic [11:0] ADDR_SEL1     = 12'h004;
    localparam int          DATA_W        = 32;
    localparam int          REG_W         = 8;

    // ========================================
    // field positions, first register
    localparam int          SEL0_PD_HI    = 7;
    localparam int          SEL0_PD_LO    = 6;
    localparam int          SEL0_PC_HI    = 5;
    localparam int          SEL0_PC_LO    = 4;
    localparam int          SEL0_PB_HI    = 3;
    localparam int          SEL0_PB_LO    = 2;
    localparam int          SEL0_PA_HI    = 1;
    localparam int          SEL0_PA_LO    = 0;

    // field positions, second register
    localparam int          SEL1_PG_HI    = 5;
    localparam int          SEL1_PG_LO    = 4;
    localparam int          SEL1_PE_LO    = 0;

    // implemented-bit masks and reset values
    localparam logic [7:0]  SEL0_MASK     = 8'hFF;
    localparam logic [7:0]  SEL1_MASK     = 8'h31;
    localparam logic [7:0]  SEL0_RST      = 8'h00;
    localparam logic [7:0]  SEL1_RST      = 8'h00;

    // drive level encoding
    localparam logic        DRIVE_MIN     = 1'b0;
    localparam logic        DRIVE_MAX     = 1'b1;

    // ========================================
    // per-nibble drive levels towards the pads
    typedef struct packed {
        logic portg_hi_nibble_drive;
        logic portg_lo_nibble_drive;
        logic porte_lo_nibble_drive;
        logic portd_hi_nibble_drive;
        logic portd_lo_nibble_drive;
        logic portc_hi_nibble_drive;
        logic portc_lo_nibble_drive;
        logic portb_hi_nibble_drive;
        logic portb_lo_nibble_drive;
        logic porta_hi_nibble_drive;
        logic porta_lo_nibble_drive;
    } pds_drive_t;

endpackage

//--- src/pds_regs.sv
// port drive-strength register bank with apb slave
// Notes on behaviour
// [RQ1] First register bit 7 drives port D upper nibble and bit 6 port D lower nibble.
// [RQ2] First register bit 5 drives port C upper nibble and bit 4 port C lower nibble.
// [RQ3] First register bit 3 drives port B upper nibble and bit 2 port B lower nibble.
// [RQ4] First register bit 1 drives port A upper nibble and bit 0 port A lower nibble.
// [RQ5] Second register bit 5 drives port G upper nibble and bit 4 port G lower nibble.
// [RQ6] Second register bit 0 drives port E lower nibble.
// [RQ7] A select bit at 0 puts its group's source and sink drivers at minimum strength.
// [RQ8] A select bit at 1 puts its group's source and sink drivers at maximum strength.
// [RQ9] Second register bits 7 to 6 and 3 to 1 ignore writes and read as zero.
// [RQ10] All implemented bits are read/write and clear to zero at reset.
`timescale 1ns/1ps

module pds_regs (
    input  wire logic               I_SYS_CLK,
    input  wire logic               I_RST_B,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [11:0]        i_paddr,
    input  wire logic [31:0]        i_pwdata,
    input  wire logic [3:0]         i_pstrb,
    output logic                    o_pready,
    output logic [31:0]             o_prdata,
    output logic                    o_pslverr,
    output pds_pkg::pds_drive_t     o_drive
);

    // ========================================
    // bus decode
    logic                 access;
    logic                 hit0;
    logic                 hit1;
    logic                 wr0;
    logic                 wr1;
    logic [7:0]           sel0_reg;
    logic [7:0]           sel1_reg;
    logic [31:0]          rdata_next;

    assign access    = i_psel & i_penable;
    assign hit0      = (i_paddr == pds_pkg::ADDR_SEL0);
    assign hit1      = (i_paddr == pds_pkg::ADDR_SEL1);
    // only the low byte lane carries register data
    assign wr0       = access & i_pwrite & hit0 & i_pstrb[0];
    assign wr1       = access & i_pwrite & hit1 & i_pstrb[0];
    // zero wait states; unmapped addresses answer with an error
    assign o_pready  = 1'b1;
    assign o_pslverr = access & ~(hit0 | hit1);

    // ========================================
    // registers
    // [RQ10] reset clears, rw access
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sel0_reg <= pds_pkg::SEL0_RST;
        end else if (wr0) begin
            sel0_reg <= i_pwdata[7:0] & pds_pkg::SEL0_MASK;
        end
    end

    // [RQ9] unimplemented bits masked off
    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sel1_reg <= pds_pkg::SEL1_RST;
        end else if (wr1) begin
            sel1_reg <= i_pwdata[7:0] & pds_pkg::SEL1_MASK;
        end
    end

    // ========================================
    // read path, registered data
    always_comb begin
        rdata_next = o_prdata;
        if (i_psel & ~i_penable & ~i_pwrite) begin
            if (hit0) begin
                rdata_next = {24'h000000, sel0_reg};
            end else if (hit1) begin
                rdata_next = {24'h000000, sel1_reg & pds_pkg::SEL1_MASK};
            end else begin
                rdata_next = 32'h00000000;
            end
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            o_prdata <= 32'h00000000;
        end else begin
            o_prdata <= rdata_next;
        end
    end

    // ========================================
    // pad level outputs
    // [RQ7] [RQ8] bit value is drive level directly
    always_comb begin
        // [RQ1] port d nibbles
        o_drive.portd_hi_nibble_drive = sel0_reg[pds_pkg::SEL0_PD_HI];
        o_drive.portd_lo_nibble_drive = sel0_reg[pds_pkg::SEL0_PD_LO];
        // [RQ2] port c nibbles
        o_drive.portc_hi_nibble_drive = sel0_reg[pds_pkg::SEL0_PC_HI];
        o_drive.portc_lo_nibble_drive = sel0_reg[pds_pkg::SEL0_PC_LO];
        // [RQ3] port b nibbles
        o_drive.portb_hi_nibble_drive = sel0_reg[pds_pkg::SEL0_PB_HI];
        o_drive.portb_lo_nibble_drive = sel0_reg[pds_pkg::SEL0_PB_LO];
        // [RQ4] port a nibbles
        o_drive.porta_hi_nibble_drive = sel0_reg[pds_pkg::SEL0_PA_HI];
        o_drive.porta_lo_nibble_drive = sel0_reg[pds_pkg::SEL0_PA_LO];
        // [RQ5] port g nibbles
        o_drive.portg_hi_nibble_drive = sel1_reg[pds_pkg::SEL1_PG_HI];
        o_drive.portg_lo_nibble_drive = sel1_reg[pds_pkg::SEL1_PG_LO];
        // [RQ6] port e low nibble
        o_drive.porte_lo_nibble_drive = sel1_reg[pds_pkg::SEL1_PE_LO];
    end

    // ========================================
    // checks
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RST_B);

    // high for the first cycle after reset so reset values can be checked
    logic first_cyc_reg;

    always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            first_cyc_reg <= 1'b1;
        end else begin
            first_cyc_reg <= 1'b0;
        end
    end

    sequence wr_sel0_s;
        access & i_pwrite & hit0 & i_pstrb[0];
    endsequence

    sequence wr_sel1_s;
        access & i_pwrite & hit1 & i_pstrb[0];
    endsequence

    sequence rd_sel0_s;
        access & ~i_pwrite & hit0;
    endsequence

    sequence rd_sel1_s;
        access & ~i_pwrite & hit1;
    endsequence

    sequence wr_nostrb0_s;
        access & i_pwrite & hit0 & ~i_pstrb[0];
    endsequence

    sequence wr_nostrb1_s;
        access & i_pwrite & hit1 & ~i_pstrb[0];
    endsequence

    sequence wr_unmapped_s;
        access & i_pwrite & ~hit0 & ~hit1;
    endsequence

    sequence rd_unmapped_s;
        access & ~i_pwrite & ~hit0 & ~hit1;
    endsequence

    property p_pd_hi_map;
        wr_sel0_s
            |=> o_drive.portd_hi_nibble_drive == $past(i_pwdata[7]);
    endproperty
    pd_hi_map_a: assert property (p_pd_hi_map) // [RQ1]
        else $error("port d high nibble drive wrong");

    property p_pd_lo_map;
        wr_sel0_s
            |=> o_drive.portd_lo_nibble_drive == $past(i_pwdata[6]);
    endproperty
    pd_lo_map_a: assert property (p_pd_lo_map) // [RQ1]
        else $error("port d low nibble drive wrong");

    property p_pc_map;
        wr_sel0_s
            |=> {o_drive.portc_hi_nibble_drive, o_drive.portc_lo_nibble_drive} == $past(i_pwdata[5:4]);
    endproperty
    pc_map_a: assert property (p_pc_map) // [RQ2]
        else $error("port c drive wrong");

    property p_pb_map;
        wr_sel0_s
            |=> {o_drive.portb_hi_nibble_drive, o_drive.portb_lo_nibble_drive} == $past(i_pwdata[3:2]);
    endproperty
    pb_map_a: assert property (p_pb_map) // [RQ3]
        else $error("port b drive wrong");

    property p_pa_map;
        wr_sel0_s
            |=> {o_drive.porta_hi_nibble_drive, o_drive.porta_lo_nibble_drive} == $past(i_pwdata[1:0]);
    endproperty
    pa_map_a: assert property (p_pa_map) // [RQ4]
        else $error("port a drive wrong");

    property p_pg_map;
        wr_sel1_s
            |=> {o_drive.portg_hi_nibble_drive, o_drive.portg_lo_nibble_drive} == $past(i_pwdata[5:4]);
    endproperty
    pg_map_a: assert property (p_pg_map) // [RQ5]
        else $error("port g drive wrong");

    property p_pe_map;
        wr_sel1_s
            |=> o_drive.porte_lo_nibble_drive == $past(i_pwdata[0]);
    endproperty
    pe_map_a: assert property (p_pe_map) // [RQ6]
        else $error("port e drive wrong");

    property p_drive_hold;
        !(wr0 || wr1)
            |=> $stable(o_drive);
    endproperty
    drive_hold_a: assert property (p_drive_hold) // [RQ10]
        else $error("drive level changed without write");

    property p_drive_set;
        wr_sel0_s ##0 i_pwdata[7]
            |=> o_drive.portd_hi_nibble_drive == pds_pkg::DRIVE_MAX;
    endproperty
    drive_set_a: assert property (p_drive_set) // [RQ8]
        else $error("max drive not applied");

    property p_sel1_unimpl;
        rd_sel1_s
            |-> o_prdata[7:6] == 2'h0 && o_prdata[3:1] == 3'h0;
    endproperty
    sel1_unimpl_a: assert property (p_sel1_unimpl) // [RQ9]
        else $error("unimplemented bits read nonzero");

    property p_read_back;
        rd_sel0_s
            |-> o_prdata[7:0] == sel0_reg;
    endproperty
    read_back_a: assert property (p_read_back) // [RQ10]
        else $error("read data mismatch");

    property p_drive_min;
        wr_sel0_s ##0 !i_pwdata[0]
            |=> o_drive.porta_lo_nibble_drive == pds_pkg::DRIVE_MIN;
    endproperty
    drive_min_a: assert property (p_drive_min) // [RQ7]
        else $error("min drive not applied on port a");

    property p_pe_min;
        wr_sel1_s ##0 !i_pwdata[0]
            |=> o_drive.porte_lo_nibble_drive == pds_pkg::DRIVE_MIN;
    endproperty
    pe_min_a: assert property (p_pe_min) // [RQ7]
        else $error("min drive not applied on port e");

    property p_pg_max;
        wr_sel1_s ##0 i_pwdata[5]
            |=> o_drive.portg_hi_nibble_drive == pds_pkg::DRIVE_MAX;
    endproperty
    pg_max_a: assert property (p_pg_max) // [RQ8]
        else $error("max drive not applied on port g");

    property p_sel1_mask;
        wr_sel1_s
            |=> (sel1_reg & ~pds_pkg::SEL1_MASK) == 8'h00;
    endproperty
    sel1_mask_a: assert property (p_sel1_mask) // [RQ9]
        else $error("unimplemented bit stored");

    property p_sel1_read;
        rd_sel1_s
            |-> o_prdata[7:0] == {2'b00, o_drive.portg_hi_nibble_drive, o_drive.portg_lo_nibble_drive,
                                  3'b000, o_drive.porte_lo_nibble_drive};
    endproperty
    sel1_read_a: assert property (p_sel1_read) // [RQ9]
        else $error("second register read differs from pads");

    property p_read_upper;
        access & ~i_pwrite
            |-> o_prdata[31:8] == 24'h000000;
    endproperty
    read_upper_a: assert property (p_read_upper) // [RQ10]
        else $error("upper read data nonzero");

    property p_strobe0;
        wr_nostrb0_s
            |=> $stable(sel0_reg);
    endproperty
    strobe_ignore0_a: assert property (p_strobe0) // [RQ10]
        else $error("write without strobe changed first register");

    property p_strobe1;
        wr_nostrb1_s
            |=> $stable(sel1_reg);
    endproperty
    strobe_ignore1_a: assert property (p_strobe1) // [RQ10]
        else $error("write without strobe changed second register");

    property p_unmapped_wr;
        wr_unmapped_s
            |=> $stable(sel0_reg) && $stable(sel1_reg);
    endproperty
    unmapped_wr_a: assert property (p_unmapped_wr) // [RQ10]
        else $error("unmapped write changed a register");

    property p_unmapped_rd;
        rd_unmapped_s
            |-> o_prdata == 32'h00000000 && o_pslverr;
    endproperty
    unmapped_rd_a: assert property (p_unmapped_rd) // [RQ10]
        else $error("unmapped read not zero with error");

    property p_pslverr_only;
        o_pslverr
            |-> i_psel && i_penable;
    endproperty
    pslverr_only_a: assert property (p_pslverr_only) // [RQ10]
        else $error("error response outside access phase");

    property p_pready;
        access
            |-> o_pready;
    endproperty
    pready_zero_a: assert property (p_pready) // [RQ10]
        else $error("access phase not ready");

    property p_post_reset;
        first_cyc_reg
            |-> o_drive == 11'h000 && o_prdata == 32'h00000000;
    endproperty
    post_reset_a: assert property (p_post_reset) // [RQ10]
        else $error("outputs not cleared after reset");

    property p_rd0_map;
        rd_sel0_s
            |-> o_prdata[7:0] == {o_drive.portd_hi_nibble_drive, o_drive.portd_lo_nibble_drive,
                                  o_drive.portc_hi_nibble_drive, o_drive.portc_lo_nibble_drive,
                                  o_drive.portb_hi_nibble_drive, o_drive.portb_lo_nibble_drive,
                                  o_drive.porta_hi_nibble_drive, o_drive.porta_lo_nibble_drive};
    endproperty
    rd0_map_a: assert property (p_rd0_map) // [RQ1]
        else $error("first register read differs from pads");

    property p_pc_min;
        wr_sel0_s ##0 !i_pwdata[5]
            |=> o_drive.portc_hi_nibble_drive == pds_pkg::DRIVE_MIN;
    endproperty
    pc_min_a: assert property (p_pc_min) // [RQ7]
        else $error("min drive not applied on port c");

    property p_pb_max;
        wr_sel0_s ##0 i_pwdata[3]
            |=> o_drive.portb_hi_nibble_drive == pds_pkg::DRIVE_MAX;
    endproperty
    pb_max_a: assert property (p_pb_max) // [RQ8]
        else $error("max drive not applied on port b");

endmodule

//--- sim/testbench.sv
// testbench: apb access and pad drive outputs of the drive-strength registers
`timescale 1ns/1ps

module testbench;
    // ========================================
    // clock, reset and bus signals
    logic                   clk;
    logic                   rst_b;
    logic                   psel;
    logic                   penable;
    logic                   pwrite;
    logic [11:0]            paddr;
    logic [31:0]            pwdata;
    logic [3:0]             pstrb;
    logic                   pready;
    logic [31:0]            prdata;
    logic                   pslverr;
    pds_pkg::pds_drive_t    drive;
    int                     num_errors = 0;
    int                     tests_run = 0;
    logic [31:0]            rd;
    logic                   err;

    pds_regs pds_regs_i (.I_SYS_CLK(clk), .I_RST_B(rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .o_drive(drive));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ========================================
    // shared tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer; a hang is left to the watchdog
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // let the write land before the caller looks at the pads
        @(posedge clk);
    endtask

    // expected pad levels from the two register values
    function automatic logic [31:0] exp_drv(input logic [7:0] r0, input logic [7:0] r1);
        return {21'h000000, r1[5], r1[4], r1[0], r0};
    endfunction

    task end_sim;
        $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ========================================
    // scenarios
    // reset gives zero and minimum drive
    task t_reset;
        chk({21'h000000, drive}, 32'h00000000);
        apb(1'b0, pds_pkg::ADDR_SEL0, 32'h00000000, 4'hF);
        chk(rd, 32'h00000000);
        apb(1'b0, pds_pkg::ADDR_SEL1, 32'h00000000, 4'hF);
        chk(rd, 32'h00000000);
        $display("test reset done");
    endtask

    // reset in mid-run clears registers, pads and read data
    task t_midreset;
        apb(1'b1, pds_pkg::ADDR_SEL0, 32'h0000005A, 4'h1);
        apb(1'b1, pds_pkg::ADDR_SEL1, 32'h00000011, 4'h1);
        chk({21'h000000, drive}, exp_drv(8'h5A, 8'h11));
        apb(1'b0, pds_pkg::ADDR_SEL0, 32'h00000000, 4'h0);
        chk(rd, 32'h0000005A);
        rst_b <= 1'b0;
        @(posedge clk);
        chk({21'h000000, drive}, 32'h00000000);
        chk(prdata, 32'h00000000);
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, pds_pkg::ADDR_SEL0, 32'h00000000, 4'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, pds_pkg::ADDR_SEL1, 32'h00000000, 4'h0);
        chk(rd, 32'h00000000);
        $display("test mid-run reset done");
    endtask

    // walking one through the first register
    task t_walk0;
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, pds_pkg::ADDR_SEL0, 32'h00000001 << k, 4'h1);
            chk({21'h000000, drive}, exp_drv(8'h01 << k, 8'h00));
            apb(1'b0, pds_pkg::ADDR_SEL0, 32'h00000000, 4'h0);
            chk(rd, 32'h00000001 << k);
        end
        apb(1'b1, pds_pkg::ADDR_SEL0, 32'h00000000, 4'h1);
        chk({21'h000000, drive}, 32'h00000000);
        $display("test first register done");
    endtask

    task t_reg1;
        apb(1'b1, pds_pkg::ADDR_SEL1, 32'hFFFFFFFF, 4'hF);
        chk({21'h000000, drive}, exp_drv(8'h00, 8'h31));
        apb(1'b0, pds_pkg::ADDR_SEL1, 32'h00000000, 4'h0);
        chk(rd, 32'h00000031);
        apb(1'b1, pds_pkg::ADDR_SEL1, 32'h000000CE, 4'h1);
        chk({21'h000000, drive}, 32'h00000000);
        $display("test second register done");
    endtask

    // refused writes leave the registers alone
    task t_refused;
        apb(1'b1, 12'h008, 32'h000000FF, 4'hF);
        chk({31'h00000000, err}, 32'h00000001);
        apb(1'b1, pds_pkg::ADDR_SEL0, 32'h000000A5, 4'h0);
        chk({21'h000000, drive}, 32'h00000000);
        apb(1'b0, 12'h008, 32'h00000000, 4'h0);
        chk(rd, 32'h00000000);
        $display("test refused done");
    endtask

    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h00000000; pstrb = 4'h0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_walk0();
        t_reg1();
        t_refused();
        t_midreset();
        end_sim();
    end

    // watchdog well above the roughly 130 cycles the tests take
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule
